// *** design/mwsr_readout.sv ***
`timescale 1ns/100ps
`include "mwsr_consts.svh"
module mwsr_readout
	import mwsr_pkg::*;
#(
	parameter int SLOTS = `MWSR_SLOTS,
	parameter int LINE_CYC = `MWSR_LINE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// readout to sensor array
	output mwsr_pix_s pix,
	output logic pix_valid,
	output logic line_valid,
	output logic frame_valid
);
	if (SLOTS != 4 || LINE_CYC < 2 || LINE_CYC > 65535) begin : g_bad_param
		$error("mwsr_readout: unsupported parameters");
	end

	localparam logic [15:0] LINE_RST = 16'(LINE_CYC);

	//----------------------------------------
	// register file
	//----------------------------------------
	logic run_q;
	logic [15:0] line_cyc_q;
	logic [SLOTS-1:0] col_en_q;
	logic [SLOTS-1:0] row_en_q;
	mwsr_win_s col_win_q [SLOTS];
	mwsr_win_s row_win_q [SLOTS];
	logic [4:0] region_cnt_q;
	logic [15:0] frame_cnt_q;
	logic waitrequest_q;
	logic [31:0] readdata_q;
	mwsr_state_e state_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [2:0] popcnt(input logic [3:0] v);
		return 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
	endfunction : popcnt

	// odd offsets and sizes are forced even
	function automatic mwsr_win_s even_win(input logic [31:0] v);
		mwsr_win_s w;
		w = mwsr_win_s'(v);
		w.rsv_hi = 5'h00;
		w.rsv_lo = 5'h00;
		w.start[0] = 1'b0;
		w.size[0] = 1'b0;
		return w;
	endfunction : even_win

	logic acc;
	logic wr_acc;
	assign acc = (read || write) && !waitrequest_q;
	assign wr_acc = write && !waitrequest_q;

	// one wait cycle, then a single-cycle answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest_q <= 1'b1;
		end else begin
			waitrequest_q <= !((read || write) && waitrequest_q);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			readdata_q <= 32'h0000_0000;
		end else if (read && waitrequest_q) begin
			readdata_q <= 32'h0000_0000;
			if (address == `MWSR_ADDR_CTRL) begin
				readdata_q[`MWSR_CTRL_RUN] <= run_q;
			end else if (address == `MWSR_ADDR_LINE) begin
				readdata_q[15:0] <= line_cyc_q;
			end else if (address == `MWSR_ADDR_EN) begin
				readdata_q[7:0] <= {row_en_q, col_en_q};
			end else if (address == `MWSR_ADDR_STAT) begin
				readdata_q[4:0] <= region_cnt_q;
				readdata_q[`MWSR_STAT_BUSY] <= (state_q != MWSR_IDLE);
				readdata_q[31:16] <= frame_cnt_q;
			end else if (address >= `MWSR_ADDR_SLOT && address <= `MWSR_ADDR_LAST
					&& address[1:0] == 2'h0) begin
				readdata_q <= address[2] ? row_win_q[address[4:3] - 2'h2]
					: col_win_q[address[4:3] - 2'h2];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			line_cyc_q <= LINE_RST;
			col_en_q <= '0;
			row_en_q <= '0;
		end else if (wr_acc) begin
			if (address == `MWSR_ADDR_CTRL && byteenable[0]) begin
				run_q <= writedata[`MWSR_CTRL_RUN];
			end else if (address == `MWSR_ADDR_LINE) begin
				line_cyc_q <= (merge({16'h0000, line_cyc_q}, writedata, byteenable) < 32'h2)
					? 16'h0002 : 16'(merge({16'h0000, line_cyc_q}, writedata, byteenable));
			end else if (address == `MWSR_ADDR_EN && byteenable[0]) begin
				col_en_q <= writedata[`MWSR_EN_COL_LSB +: 4];
				row_en_q <= writedata[`MWSR_EN_ROW_LSB +: 4];
			end
		end
	end

	genvar gs;
	generate
		for (gs = 0; gs < SLOTS; gs++) begin : g_slot
			always_ff @(posedge clk_sys or negedge rst_n) begin
				if (!rst_n) begin
					col_win_q[gs] <= '0;
					row_win_q[gs] <= '0;
				end else if (wr_acc && address == 8'(`MWSR_ADDR_SLOT + gs * `MWSR_SLOT_STRIDE)) begin
					col_win_q[gs] <= even_win(merge(col_win_q[gs], writedata, byteenable));
				end else if (wr_acc
						&& address == 8'(`MWSR_ADDR_SLOT + gs * `MWSR_SLOT_STRIDE + 4)) begin
					row_win_q[gs] <= even_win(merge(row_win_q[gs], writedata, byteenable));
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			region_cnt_q <= 5'h00;
		end else begin
			region_cnt_q <= 5'(popcnt(col_en_q)) * 5'(popcnt(row_en_q));
		end
	end

	//----------------------------------------
	// scan engine
	//----------------------------------------
	logic [15:0] cyc_q;
	logic [1:0] cw_q;
	logic [1:0] rw_q;
	mwsr_coord_t col_off_q;
	mwsr_coord_t row_off_q;
	logic col_done_q;
	logic [5:0] inv_q;
	logic col_first_ok, col_next_ok, row_first_ok, row_next_ok;
	logic [1:0] col_first, col_next, row_first, row_next;
	logic line_end;

	assign line_end = (cyc_q == line_cyc_q - 16'h0001);

	// separate window search instances for the first and next row and column windows
	mwsr_next_win #(.SLOTS(SLOTS)) u_col_first (.en(col_en_q), .from(3'h0),
		.found(col_first_ok), .idx(col_first));
	mwsr_next_win #(.SLOTS(SLOTS)) u_col_next (.en(col_en_q), .from(3'(cw_q) + 3'h1),
		.found(col_next_ok), .idx(col_next));
	mwsr_next_win #(.SLOTS(SLOTS)) u_row_first (.en(row_en_q), .from(3'h0),
		.found(row_first_ok), .idx(row_first));
	mwsr_next_win #(.SLOTS(SLOTS)) u_row_next (.en(row_en_q), .from(3'(rw_q) + 3'h1),
		.found(row_next_ok), .idx(row_next));

	// every line lasts the full line period
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= 16'h0000;
		end else if (state_q == MWSR_IDLE || line_end) begin
			cyc_q <= 16'h0000;
		end else begin
			cyc_q <= cyc_q + 16'h0001;
		end
	end

	// active rows, then forty invalid lines
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= MWSR_IDLE;
			rw_q <= 2'h0;
			row_off_q <= '0;
			inv_q <= 6'h00;
			frame_cnt_q <= 16'h0000;
		end else begin
			case (state_q)
				MWSR_IDLE: begin
					if (run_q && row_first_ok && col_first_ok) begin
						state_q <= MWSR_ACTIVE;
						rw_q <= row_first;
						row_off_q <= '0;
					end
				end
				MWSR_ACTIVE: begin
					if (line_end) begin
						if (row_off_q + 11'h001 < row_win_q[rw_q].size) begin
							row_off_q <= row_off_q + 11'h001;
						end else if (row_next_ok) begin
							rw_q <= row_next;
							row_off_q <= '0;
						end else begin
							state_q <= MWSR_INVALID;
							inv_q <= 6'h00;
						end
					end
				end
				MWSR_INVALID: begin
					if (line_end) begin
						inv_q <= inv_q + 6'h01;
						if (inv_q == 6'(`MWSR_INVALID_LINES - 1)) begin
							frame_cnt_q <= frame_cnt_q + 16'h0001;
							state_q <= MWSR_IDLE;
						end
					end
				end
				default: begin
					state_q <= MWSR_IDLE;
				end
			endcase
		end
	end

	// column walk packs enabled column windows back to back
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cw_q <= 2'h0;
			col_off_q <= '0;
			col_done_q <= 1'b1;
		end else if (cyc_q == 16'h0000) begin
			cw_q <= col_first;
			col_off_q <= '0;
			col_done_q <= !col_first_ok || state_q != MWSR_ACTIVE;
		end else if (!col_done_q) begin
			if (col_off_q + 11'h001 < col_win_q[cw_q].size) begin
				col_off_q <= col_off_q + 11'h001;
			end else if (col_next_ok) begin
				cw_q <= col_next;
				col_off_q <= '0;
			end else begin
				col_done_q <= 1'b1;
			end
		end
	end

	//----------------------------------------
	// registered outputs
	//----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pix <= '0;
			pix_valid <= 1'b0;
			line_valid <= 1'b0;
			frame_valid <= 1'b0;
		end else begin
			// only enabled windows reach the pixel stream
			pix_valid <= state_q == MWSR_ACTIVE && !col_done_q && cyc_q != 16'h0000
				&& col_en_q[cw_q] && row_en_q[rw_q];
			pix.col <= 11'(col_win_q[cw_q].start + col_off_q);
			pix.row <= 11'(row_win_q[rw_q].start + row_off_q);
			line_valid <= state_q == MWSR_ACTIVE;
			frame_valid <= state_q == MWSR_ACTIVE;
		end
	end

	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;

	//----------------------------------------
	// checks
	//----------------------------------------
	logic [15:0] since_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			since_q <= 16'h0000;
		end else begin
			since_q <= (state_q == MWSR_IDLE || line_end) ? 16'h0000 : since_q + 16'h0001;
		end
	end

	sequence s_wr_slot0;
		wr_acc && address == `MWSR_ADDR_SLOT && byteenable == 4'hF;
	endsequence

	AST_REGION_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
		##1 region_cnt_q == 5'($past(popcnt(col_en_q))) * 5'($past(popcnt(row_en_q))))
		else $error("region count wrong");
	AST_PIX_COL_IN_WIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(pix_valid) |-> $past(col_off_q) < $past(col_win_q[cw_q].size) || $past(col_off_q) == 0)
		else $error("pixel outside column window");
	AST_PIX_ENABLED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pix_valid |-> $past(col_en_q[cw_q]) && $past(row_en_q[rw_q]))
		else $error("pixel from disabled window");
	AST_ROW_IN_WIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == MWSR_ACTIVE |-> row_off_q < row_win_q[rw_q].size || row_off_q == 0)
		else $error("row outside row window");
	AST_LINE_PERIOD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		line_end && state_q != MWSR_IDLE |-> since_q == line_cyc_q - 16'h0001)
		else $error("line period not kept");
	AST_INVALID_LINES: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == MWSR_INVALID && $past(state_q) == MWSR_INVALID |-> inv_q < 6'h28)
		else $error("invalid line count exceeded");
	AST_PACKED: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pix_valid ##1 pix_valid |-> pix.col > $past(pix.col))
		else $error("packed columns not increasing");
	AST_SLOT_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_wr_slot0 |=> col_win_q[0].start == {$past(writedata[10:1]), 1'b0})
		else $error("slot write lost");
	AST_SLOTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
		region_cnt_q <= 5'h10) else $error("more than sixteen regions");
	AST_LINE_MIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
		line_cyc_q >= 16'h0002) else $error("line period too short");
endmodule : mwsr_readout

// *** design/mwsr_consts.svh ***
`ifndef MWSR_CONSTS_SVH
`define MWSR_CONSTS_SVH

// register byte addresses
`define MWSR_ADDR_CTRL 8'h00
`define MWSR_ADDR_LINE 8'h04
`define MWSR_ADDR_EN 8'h08
`define MWSR_ADDR_STAT 8'h0C
`define MWSR_ADDR_SLOT 8'h10
`define MWSR_SLOT_STRIDE 8'h08
`define MWSR_ADDR_LAST 8'h2C

// field positions
`define MWSR_CTRL_RUN 0
`define MWSR_EN_COL_LSB 0
`define MWSR_EN_ROW_LSB 4
`define MWSR_STAT_BUSY 5
`define MWSR_STAT_FCNT_LSB 16

// sensor geometry and frame timing
`define MWSR_SLOTS 4
`define MWSR_COL_LIMIT 1936
`define MWSR_ROW_LIMIT 1216
`define MWSR_INVALID_LINES 40
`define MWSR_CLK_HZ 250000000
`define MWSR_LINE_RATE_HZ 76076
`define MWSR_LINE_CYC (`MWSR_CLK_HZ / `MWSR_LINE_RATE_HZ)

`endif

// *** design/mwsr_pkg.sv ***
package mwsr_pkg;
	typedef logic [10:0] mwsr_coord_t;
	// one window: start in the low half, size in the high half
	typedef struct packed {
		logic [4:0] rsv_hi;
		mwsr_coord_t size;
		logic [4:0] rsv_lo;
		mwsr_coord_t start;
	} mwsr_win_s;
	typedef enum logic [1:0] {MWSR_IDLE, MWSR_ACTIVE, MWSR_INVALID} mwsr_state_e;
	// pixel coordinate handed to the sensor array
	typedef struct packed {
		mwsr_coord_t col;
		mwsr_coord_t row;
	} mwsr_pix_s;
endpackage : mwsr_pkg

// *** design/mwsr_next_win.sv ***
`timescale 1ns/100ps
module mwsr_next_win
	import mwsr_pkg::*;
#(
	parameter int SLOTS = 4
) (
	// search request
	input wire logic [SLOTS-1:0] en,
	input wire logic [2:0] from,
	// result
	output logic found,
	output logic [1:0] idx
);
	if (SLOTS != 4) begin : g_bad_slots
		$error("mwsr_next_win: only four slots supported");
	end

	// lowest enabled slot at or above from
	always_comb begin
		found = 1'b0;
		idx = 2'h0;
		for (int i = SLOTS - 1; i >= 0; i--) begin
			if (en[i] && (3'(i) >= from)) begin
				found = 1'b1;
				idx = 2'(i);
			end
		end
	end
endmodule : mwsr_next_win

// *** dv/mwsr_frame_rx.sv ***
`timescale 1ns/100ps
module mwsr_frame_rx
	import mwsr_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// readout stream
	input wire mwsr_pix_s pix,
	input wire logic pix_valid,
	input wire logic line_valid,
	input wire logic frame_valid,
	// frame summary, done pulses at frame end
	output logic done,
	output logic [15:0] npix,
	output logic [15:0] nact,
	output logic [15:0] period,
	output logic [15:0] nlv,
	output mwsr_pix_s first
);
	logic fv_q;
	logic [15:0] pc_q;
	logic [15:0] ac_q;
	logic [15:0] tc_q;
	logic [15:0] lc_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fv_q <= 1'b0;
			pc_q <= 16'h0;
			ac_q <= 16'h0;
			tc_q <= 16'h0;
			lc_q <= 16'h0;
			nlv <= 16'h0;
			done <= 1'b0;
			npix <= 16'h0;
			nact <= 16'h0;
			period <= 16'h0;
			first <= '0;
		end else begin
			fv_q <= frame_valid;
			done <= fv_q && !frame_valid;
			tc_q <= tc_q + 16'h1;
			if (frame_valid && !fv_q) begin
				// frame start: restart counts, keep start-to-start time
				period <= tc_q;
				tc_q <= 16'h1;
				ac_q <= 16'h1;
				pc_q <= {15'h0, pix_valid};
				lc_q <= {15'h0, line_valid};
			end else begin
				if (line_valid)
					lc_q <= lc_q + 16'h1;
				if (frame_valid)
					ac_q <= ac_q + 16'h1;
				if (pix_valid)
					pc_q <= pc_q + 16'h1;
			end
			if (pix_valid && (pc_q == 16'h0 || (frame_valid && !fv_q)))
				first <= pix;
			if (fv_q && !frame_valid) begin
				npix <= pc_q;
				nact <= ac_q;
				nlv <= lc_q;
			end
		end
	end
endmodule : mwsr_frame_rx

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "mwsr_consts.svh"
module tb_top
	import mwsr_pkg::*;
;
	localparam int LC = 80;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'hF;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	mwsr_pix_s pix;
	mwsr_pix_s first;
	logic pix_valid, line_valid, frame_valid, done;
	logic [15:0] npix, nact, period, nlv;
	logic [63:0] exp_rd[$];
	logic [69:0] exp_fr[$];
	logic [63:0] r;
	logic [69:0] f;
	logic [7:0] en_tab[6] = '{8'h11, 8'h33, 8'h13, 8'h77, 8'h7F, 8'hFF};
	logic [7:0] en;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;
	int unsigned seed;
	always #2 clk_sys = ~clk_sys;
	mwsr_readout #(.LINE_CYC(LC)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .pix(pix), .pix_valid(pix_valid),
		.line_valid(line_valid), .frame_valid(frame_valid));
	mwsr_frame_rx rx (.clk_sys(clk_sys), .rst_n(rst_n), .pix(pix), .pix_valid(pix_valid),
		.line_valid(line_valid), .frame_valid(frame_valid), .done(done), .npix(npix),
		.nact(nact), .period(period), .nlv(nlv), .first(first));
	// ----------------------------------------
	// bus tasks and compares
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_rd.push_back({m, e});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic win(input logic [7:0] a, input logic [10:0] st, input logic [10:0] sz);
		bus(1'b1, a, {5'h0, sz, 5'h0, st});
	endtask : win
	task automatic fail(input logic [69:0] g, input logic [69:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : fail
	task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
		fail({38'h0, g}, {38'h0, e});
	endtask : cmp_rd
	task automatic cmp_fr(input logic [69:0] g, input logic [69:0] e);
		fail(g, e);
	endtask : cmp_fr
	task automatic cmp_ln(input logic [15:0] g, input logic [15:0] e);
		fail({54'h0, g}, {54'h0, e});
	endtask : cmp_ln
	task automatic results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	always @(posedge clk_sys) begin
		if (read && waitrequest === 1'b0) begin
			r = exp_rd.pop_front();
			cmp_rd(readdata & r[63:32], r[31:0]);
		end
		if (done === 1'b1) begin
			f = (exp_fr.size() != 0) ? exp_fr.pop_front() : {70{1'b1}};
			cmp_fr({npix, nact, (f[37:22] == 16'h0) ? 16'h0 : period, first}, f);
			cmp_ln(nlv, f[53:38]);
		end
		cyc++;
		if (cyc == 16000) begin
			n_fail++;
			results();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = $urandom(32'h87C4667F);
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		bus(1'b1, 8'h30, 32'hFFFFFFFF);
		rd(8'h30, 32'h0, 32'hFFFFFFFF);
		bus(1'b1, `MWSR_ADDR_LINE, LC);
		for (int i = 0; i < 12; i++) begin
			en = (i < 6) ? en_tab[i] : 8'($urandom());
			bus(1'b1, `MWSR_ADDR_EN, {24'h0, en});
			rd(`MWSR_ADDR_STAT, 32'($countones(en[3:0]) * $countones(en[7:4])), 32'h1F);
		end
		win(8'h10, 11'h000, 11'h010);
		win(8'h18, 11'h020, 11'h010);
		win(8'h20, 11'h040, 11'h010);
		win(8'h28, 11'h060, 11'h010);
		win(8'h14, 11'd0, 11'd2);
		win(8'h1C, 11'd4, 11'd2);
		win(8'h24, 11'd10, 11'd4);
		win(8'h2C, 11'd20, 11'd2);
		bus(1'b1, `MWSR_ADDR_EN, 32'h6A);
		exp_fr.push_back({16'h00C0, 16'(6 * LC), 16'h0, 11'h020, 11'h004});
		exp_fr.push_back({16'h00C0, 16'(6 * LC), 16'((46 * LC) + 1), 11'h020, 11'h004});
		bus(1'b1, `MWSR_ADDR_CTRL, 32'h1);
		while (exp_fr.size() != 0) @(posedge clk_sys);
		bus(1'b1, `MWSR_ADDR_CTRL, 32'h0);
		repeat (45 * LC) @(posedge clk_sys);
		rd(`MWSR_ADDR_STAT, 32'h00020000, 32'hFFFF0000);
		bus(1'b1, `MWSR_ADDR_EN, 32'h6F);
		exp_fr.push_back({16'h0180, 16'(6 * LC), 16'h0, 11'h000, 11'h004});
		bus(1'b1, `MWSR_ADDR_CTRL, 32'h1);
		while (exp_fr.size() != 0) @(posedge clk_sys);
		bus(1'b1, `MWSR_ADDR_CTRL, 32'h0);
		repeat (45 * LC) @(posedge clk_sys);
		rd(`MWSR_ADDR_STAT, 32'h00030008, 32'hFFFF003F);
		repeat (4) @(posedge clk_sys);
		results();
	end
endmodule : tb_top
